/* File: hw/cca_array.sv */
/*
  four-channel capture/compare array with its sfr access points and flags.
  assumes a byte-wide sfr bus with one-cycle read/write strobes on clk_sys, and
  a timer that accepts a one-cycle clear pulse; pins pass the local synchroniser.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cca_consts.svh"
// How it works
// [R1] a flag interrupts only with its channel enable and the array enable set
// [R2] in dual-slope mode each event stores count direction, up 0 down 1
// [R3] software writes to the direction bit change nothing
// [R4] with clear-timer set, an event clears both timer bytes
// [R5] with clear-timer zero, events leave the timer alone
// [R6] mode bit 1 means compare, 0 means capture
// [R7] capture codes 000 off, 001 falling, 010 rising, 011 either edge
// [R8] capture codes 100/101 timer0/1 overflow, 110/111 comparator A/B
// [R9] compare codes 000 flag only, 001 set, 010 clear, 011 toggle pin
// [R10] compare 100 inverting pwm, 101 non-inverting, 110/111 reserved
// [R11] the control access point reaches only the indexed channel's byte
// [R12] comparator triggers follow the comparator's own event configuration
// [R13] pwm alignment comes from the timer count mode
// [R14] flag register bit n is channel n's event flag, set by events
// [R15] software clears the flags; hardware never does
// [R16] flag register at 0xd5, reset clears low four bits, upper unimplemented
// [R17] a capture copies the timer count into data and sets the flag
// [R18] compare event when data equals timer count
// [R19] a 2-bit index selects the channel behind the access points
// [R20] compare outputs reset to 1
// [R21] reserved compare codes leave the pin, still flag
// [R22] disabled capture code never flags nor captures
module cca_array
  import cca_pkg::*;
#(
  parameter int NUM_CH = 4
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  // sfr bus
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_we,
  input wire logic sfr_re,
  output logic [7:0] sfr_rdata,
  // array-wide interrupt enable and request
  input wire logic array_irq_enable,
  output logic irq_r,
  // timer side
  input wire logic [15:0] timer_count,
  input wire logic dual_slope,
  input wire logic count_down,
  input wire logic [NUM_CH-1:0] pwm_level,
  output logic timer_clear_r,
  // internal trigger pulses, already conditioned by their sources
  input wire logic t0_ovf,
  input wire logic t1_ovf,
  input wire logic cmp_a_evt,
  input wire logic cmp_b_evt,
  // channel pins
  input wire logic [NUM_CH-1:0] channel_pin_in,
  output logic [NUM_CH-1:0] channel_pin_out
);
  logic [1:0] channel_index_r;
  logic [7:0] data_high_shadow_r;
  logic [3:0] event_flag_r;
  logic [NUM_CH-1:0] evt;
  logic [NUM_CH-1:0] clr_req;
  logic [NUM_CH-1:0] irq_en;
  logic [7:0] ctl_all [NUM_CH];
  logic [15:0] data_all [NUM_CH];

  // address decode
  wire hit_index = sfr_addr == `ADDR_CHANNEL_INDEX;
  wire hit_high = sfr_addr == `ADDR_DATA_HIGH;
  wire hit_low = sfr_addr == `ADDR_DATA_LOW;
  wire hit_ctl = sfr_addr == `ADDR_CONTROL_ACCESS;
  wire hit_flags = sfr_addr == `ADDR_EVENT_FLAGS;
  wire [15:0] data_wval = {data_high_shadow_r, sfr_wdata};

  // per-channel instances
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      logic lvl;
      wire sel = channel_index_r == 2'(g); // R19
      pin_sync u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .clk_en(clk_en),
        .pin_in(channel_pin_in[g]),
        .level_out(lvl)
      );
      cca_channel u_ch (
        .clk_sys(clk_sys),
        .rst(rst),
        .clk_en(clk_en),
        .ctl_we(sfr_we && hit_ctl && sel), // R11
        .data_we(sfr_we && hit_low && sel),
        .wdata(sfr_wdata),
        .data_wval(data_wval),
        .timer_count(timer_count),
        .dual_slope(dual_slope),
        .count_down(count_down),
        .pwm_level(pwm_level[g]),
        .t0_ovf(t0_ovf),
        .t1_ovf(t1_ovf),
        .cmp_a_evt(cmp_a_evt),
        .cmp_b_evt(cmp_b_evt),
        .pin_level(lvl),
        .ctl_r(ctl_all[g]),
        .data_r(data_all[g]),
        .pin_out_r(channel_pin_out[g]),
        .event_out(evt[g])
      );
      assign clr_req[g] = evt[g] & ctl_all[g][`CTL_CLEAR_BIT]; // R4 R5
      assign irq_en[g] = ctl_all[g][`CTL_IRQ_EN_BIT];
    end
  endgenerate

  // read mux; unimplemented bits read zero
  wire [7:0] ctl_sel = ctl_all[channel_index_r]; // R11
  wire [15:0] data_sel = data_all[channel_index_r];
  wire [7:0] rd_mux = hit_index ? {6'h00, channel_index_r} :
                      hit_high ? data_sel[15:8] :
                      hit_low ? data_sel[7:0] :
                      hit_ctl ? (ctl_sel & 8'hdf) :
                      hit_flags ? {4'h0, event_flag_r} : 8'h00;

  // flags: event set wins over software clear
  wire [3:0] flag_nxt = ((sfr_we && hit_flags) ? sfr_wdata[3:0] : event_flag_r) | evt; // R14 R15

  // index, shadow and flag registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      channel_index_r <= 2'h0;
      data_high_shadow_r <= 8'h00;
      event_flag_r <= `RST_FLAGS; // R16
    end else if (clk_en) begin
      if (sfr_we && hit_index) begin
        channel_index_r <= sfr_wdata[1:0];
      end
      if (sfr_we && hit_high) begin
        data_high_shadow_r <= sfr_wdata;
      end
      event_flag_r <= flag_nxt; // R17
    end
  end

  // registered outputs: read data, interrupt, timer clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
      irq_r <= 1'b0;
      timer_clear_r <= 1'b0;
    end else if (clk_en) begin
      sfr_rdata <= sfr_re ? rd_mux : 8'h00;
      irq_r <= array_irq_enable && |(event_flag_r & irq_en); // R1
      timer_clear_r <= |clr_req; // R4
    end
  end
endmodule // cca_array
`default_nettype wire

/* File: hw/cca_channel.sv */
/*
  one capture/compare channel: control byte, data word, trigger and pin action.
  assumes synchronised pin level and single-cycle event pulses from the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cca_consts.svh"
module cca_channel
  import cca_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  // register writes for this channel
  input wire logic ctl_we,
  input wire logic data_we,
  input wire logic [7:0] wdata,
  input wire logic [15:0] data_wval,
  // timer and event sources
  input wire logic [15:0] timer_count,
  input wire logic dual_slope,
  input wire logic count_down,
  input wire logic pwm_level,
  input wire logic t0_ovf,
  input wire logic t1_ovf,
  input wire logic cmp_a_evt,
  input wire logic cmp_b_evt,
  input wire logic pin_level,
  // state out
  output logic [7:0] ctl_r,
  output logic [15:0] data_r,
  output logic pin_out_r,
  output logic event_out
);
  logic pin_prev_r;
  wire compare_not_capture = ctl_r[`CTL_MODE_BIT];
  wire [2:0] chan_event_select = ctl_r[`CTL_SEL_HI:`CTL_SEL_LO];
  wire rise = pin_level & ~pin_prev_r;
  wire fall = ~pin_level & pin_prev_r;
  logic cap_hit;

  // capture trigger decode; disabled code never fires
  always_comb begin
    unique case (capture_sel_t'(chan_event_select))
      CAP_OFF: cap_hit = 1'b0; // R22
      CAP_FALL: cap_hit = fall; // R7
      CAP_RISE: cap_hit = rise;
      CAP_BOTH: cap_hit = rise | fall;
      CAP_T0_OVF: cap_hit = t0_ovf; // R8
      CAP_T1_OVF: cap_hit = t1_ovf;
      CAP_CMP_A: cap_hit = cmp_a_evt; // R12
      CAP_CMP_B: cap_hit = cmp_b_evt;
    endcase
  end

  wire cmp_hit = compare_not_capture & (data_r == timer_count); // R18
  assign event_out = compare_not_capture ? cmp_hit : cap_hit; // R6
  wire is_pwm = chan_event_select[2:1] == 2'b10;

  // control byte; direction bit only written by events
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctl_r <= `RST_CONTROL;
    end else if (clk_en) begin
      if (ctl_we) begin
        ctl_r <= (wdata & `CTL_WRITE_MASK) | (ctl_r & ~`CTL_WRITE_MASK); // R3
      end
      if (event_out && dual_slope) begin
        ctl_r[`CTL_DIR_BIT] <= count_down; // R2
      end
    end
  end

  // data word: capture copy or software write in compare mode
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      data_r <= `RST_DATA;
      pin_prev_r <= 1'b1;
    end else if (clk_en) begin
      pin_prev_r <= pin_level;
      if (!compare_not_capture && cap_hit) begin
        data_r <= timer_count; // R17
      end else if (data_we && compare_not_capture) begin
        data_r <= data_wval;
      end
    end
  end

  // compare output pin action
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_out_r <= `RST_PIN_OUT; // R20
    end else if (clk_en && compare_not_capture) begin
      if (is_pwm) begin
        // alignment comes from the timer's count mode via pwm_level
        pin_out_r <= (chan_event_select[0] ? pwm_level : ~pwm_level); // R10 R13
      end else if (cmp_hit) begin
        unique case (compare_act_t'(chan_event_select))
          ACT_SET: pin_out_r <= 1'b1; // R9
          ACT_CLEAR: pin_out_r <= 1'b0;
          ACT_TOGGLE: pin_out_r <= ~pin_out_r;
          default: pin_out_r <= pin_out_r; // R21
        endcase
      end
    end
  end
endmodule // cca_channel
`default_nettype wire

/* File: hw/cca_consts.svh */
/*
  sfr offsets, control byte fields and reset values of the capture/compare array.
  assumes an 8-bit special-function-register bus with byte addresses.
*/
`ifndef CCA_CONSTS_SVH
`define CCA_CONSTS_SVH

// sfr byte addresses
`define ADDR_CHANNEL_INDEX 8'hd1
`define ADDR_DATA_HIGH 8'hd2
`define ADDR_DATA_LOW 8'hd3
`define ADDR_CONTROL_ACCESS 8'hd4
`define ADDR_EVENT_FLAGS 8'hd5

// control byte fields
`define CTL_IRQ_EN_BIT 7
`define CTL_DIR_BIT 6
`define CTL_CLEAR_BIT 4
`define CTL_MODE_BIT 3
`define CTL_SEL_HI 2
`define CTL_SEL_LO 0
// writable bits of the control byte: direction and bit 5 excluded
`define CTL_WRITE_MASK 8'h9f

// reset values
`define RST_CONTROL 8'h00
`define RST_FLAGS 4'h0
`define RST_DATA 16'h0000
`define RST_PIN_OUT 1'b1

`endif

/* File: hw/cca_pkg.sv */
/*
  types of the capture/compare array.
  assumes cca_consts.svh holds the numeric constants.
*/
package cca_pkg;
  // capture trigger sources
  typedef enum logic [2:0] {
    CAP_OFF = 3'b000,
    CAP_FALL = 3'b001,
    CAP_RISE = 3'b010,
    CAP_BOTH = 3'b011,
    CAP_T0_OVF = 3'b100,
    CAP_T1_OVF = 3'b101,
    CAP_CMP_A = 3'b110,
    CAP_CMP_B = 3'b111
  } capture_sel_t;
  // compare output actions
  typedef enum logic [2:0] {
    ACT_NONE = 3'b000,
    ACT_SET = 3'b001,
    ACT_CLEAR = 3'b010,
    ACT_TOGGLE = 3'b011,
    ACT_PWM_INV = 3'b100,
    ACT_PWM_NONINV = 3'b101,
    ACT_RSVD_6 = 3'b110,
    ACT_RSVD_7 = 3'b111
  } compare_act_t;
endpackage

/* File: hw/pin_sync.sv */
/*
  three-stage synchroniser for a pin; a change counts when stages two and three agree.
  assumes a single clock and a clock enable.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  // pin and filtered level
  input wire logic pin_in,
  output logic level_out
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // sampling chain; idle level high, like a pulled-up pin
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      level_out <= 1'b1;
    end else if (clk_en) begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_out <= s3_r;
      end
    end
  end
endmodule // pin_sync
`default_nettype wire

/* File: tb/cca_array_chk.sv */
/* checker on the array ports: read data, irq, reset state, freeze.
   assumes it is bound onto cca_array. */
`timescale 1ns/1ps
`default_nettype none
module cca_array_chk #(
  parameter int NUM_CH = 4
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  // sfr bus
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_we,
  input wire logic sfr_re,
  input wire logic [7:0] sfr_rdata,
  // interrupt enable and outputs
  input wire logic array_irq_enable,
  input wire logic irq_r,
  input wire logic timer_clear_r,
  input wire logic [NUM_CH-1:0] channel_pin_out
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // index write then read back
  sequence idx_wr; sfr_we && clk_en && sfr_addr == 8'hd1; endsequence
  sequence idx_rd; sfr_re && clk_en && sfr_addr == 8'hd1; endsequence
  irq_off_a: assert property (clk_en && !array_irq_enable |=> !irq_r)
    else $error("irq without array enable");
  idle_rd_a: assert property (!sfr_re |=> sfr_rdata == 8'h00)
    else $error("read data not idle");
  flag_hi_a: assert property (sfr_re && clk_en && sfr_addr == 8'hd5 |=> sfr_rdata[7:4] == 4'h0)
    else $error("flag upper bits set");
  unmapped_a: assert property (sfr_re && !(sfr_addr inside {[8'hd1:8'hd5]}) |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  index_rb_a: assert property (idx_wr ##2 idx_rd |=> (sfr_rdata & 8'h03) == ($past(sfr_wdata, 3) & 8'h03))
    else $error("index read back wrong");
  ctl_bit5_a: assert property (sfr_re && clk_en && sfr_addr == 8'hd4 |=> !sfr_rdata[5])
    else $error("control bit 5 set");
  rst_out_a: assert property (disable iff (1'b0) rst ##1 rst |-> &channel_pin_out && !irq_r && !timer_clear_r)
    else $error("reset outputs wrong");
  freeze_a: assert property (!clk_en |=> $stable(channel_pin_out) && $stable(irq_r))
    else $error("outputs moved while frozen");
endmodule // cca_array_chk
bind cca_array cca_array_chk #(.NUM_CH(NUM_CH)) chk_i (.clk_sys, .rst, .clk_en, .sfr_addr,
  .sfr_wdata, .sfr_we, .sfr_re, .sfr_rdata, .array_irq_enable, .irq_r, .timer_clear_r,
  .channel_pin_out);
`default_nettype wire

/* File: tb/cca_timer_model.sv */
/* timer stand-in: up counter that idles at all ones.
   assumes run comes from the bench; clears on the array's request. */
`timescale 1ns/1ps
`default_nettype none
module cca_timer_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // control
  input wire logic run,
  input wire logic timer_clear_r,
  // count
  output logic [15:0] timer_count
);
  // idle value never matches the bench data, wraps to zero on start
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      timer_count <= 16'hffff;
    end else if (!run) begin
      timer_count <= 16'hffff;
    end else if (timer_clear_r) begin
      timer_count <= 16'h0000;
    end else begin
      timer_count <= timer_count + 16'h0001;
    end
  end
endmodule // cca_timer_model
`default_nettype wire

/* File: tb/tb_cca_array.sv */
/* self-checking bench of the capture/compare array.
   assumes the design, checker and timer model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb_cca_array;
  // stimulus, driven at falling edges
  logic clk_sys = 1'b0, rst = 1'b1, clk_en = 1'b1, we = 1'b0, re = 1'b0;
  logic aie = 1'b0, ds = 1'b0, cd = 1'b0, run = 1'b0, irq, tclr;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdata;
  logic [3:0] pwm = 4'h0, ev = 4'h0, pin = 4'h0, pout;
  logic [15:0] tc;
  int error_cnt = 0, tests_run = 0;
  cca_array DUT (.clk_sys, .rst, .clk_en, .sfr_addr(addr), .sfr_wdata(wd), .sfr_we(we),
    .sfr_re(re), .sfr_rdata(rdata), .array_irq_enable(aie), .irq_r(irq), .timer_count(tc),
    .dual_slope(ds), .count_down(cd), .pwm_level(pwm), .timer_clear_r(tclr),
    .t0_ovf(ev[0]), .t1_ovf(ev[1]), .cmp_a_evt(ev[2]), .cmp_b_evt(ev[3]),
    .channel_pin_in(pin), .channel_pin_out(pout));
  cca_timer_model far (.clk_sys, .rst, .run, .timer_clear_r(tclr), .timer_count(tc));
  // compare, bus cycles and waits
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h wanted %h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    addr = a;
    wd = d;
    we = 1'b1;
    @(negedge clk_sys);
    we = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
    @(negedge clk_sys);
    addr = a;
    re = 1'b1;
    @(negedge clk_sys);
    re = 1'b0;
    chk(rdata & m, e);
  endtask
  task automatic fl(input logic [7:0] e);
    cyc(8);
    rd(8'hd5, e);
    wr(8'hd5, 8'h00);
  endtask
  // scenarios
  task automatic t_rst();
    chk({4'h0, pout}, 8'h0f);
    rd(8'hd5, 8'h00);
    wr(8'hd0, 8'h5a);
    rd(8'hd0, 8'h00);
    wr(8'hd1, 8'h03);
    rd(8'hd1, 8'h03, 8'h03);
    wr(8'hd5, 8'hff);
    fl(8'h0f);
    $display("t_rst end");
  endtask
  task automatic t_cmp();
    logic [2:0] act [6] = '{3'h2, 3'h0, 3'h1, 3'h6, 3'h3, 3'h7};
    logic [5:0] pv = 6'b001100;
    int i;
    wr(8'hd1, 8'h02);
    for (i = 0; i < 6; i++) begin
      wr(8'hd4, {5'h01, act[i]});
      wr(8'hd2, 8'h00);
      wr(8'hd3, 8'h10);
      run = 1'b1;
      cyc(30);
      chk(8'(tc > 16'h0010), 8'h01);
      run = 1'b0;
      chk({7'h0, pout[2]}, {7'h0, pv[i]});
      fl(8'h04);
    end
    $display("t_cmp end");
  endtask
  task automatic t_ctc();
    logic [15:0] mx = 16'h0000;
    wr(8'hd4, 8'h98);
    ds = 1'b1;
    cd = 1'b1;
    run = 1'b1;
    repeat (40) begin
      @(negedge clk_sys);
      if (tc > mx) mx = tc;
    end
    run = 1'b0;
    chk(8'(mx < 16'h0013), 8'h01);
    chk({7'h0, irq}, 8'h00);
    aie = 1'b1;
    cyc(3);
    chk({7'h0, irq}, 8'h01);
    rd(8'hd4, 8'hd8);
    wr(8'hd4, 8'h98);
    rd(8'hd4, 8'hd8);
    fl(8'h04);
    cyc(1);
    chk({7'h0, irq}, 8'h00);
    wr(8'hd4, 8'h18);
    wr(8'hd5, 8'h04);
    cyc(2);
    chk({7'h0, irq}, 8'h00);
    wr(8'hd5, 8'h00);
    wr(8'hd4, 8'h98);
    ds = 1'b0;
    $display("t_ctc end");
  endtask
  task automatic t_cap();
    int k, j;
    wr(8'hd1, 8'h00);
    for (k = 0; k < 8; k++) begin
      wr(8'hd4, 8'(k));
      @(negedge clk_sys) pin[0] = 1'b1;
      fl(8'(k == 2 || k == 3));
      @(negedge clk_sys) pin[0] = 1'b0;
      fl(8'(k == 1 || k == 3));
      for (j = 0; j < 4; j++) begin
        @(negedge clk_sys) ev[j] = 1'b1;
        @(negedge clk_sys) ev[j] = 1'b0;
        fl(8'(k == j + 4));
      end
      if (k == 0) rd(8'hd3, 8'h00);
    end
    rd(8'hd2, 8'hff);
    wr(8'hd1, 8'h02);
    rd(8'hd4, 8'hd8);
    $display("t_cap end");
  endtask
  task automatic t_pwm();
    int i;
    for (i = 0; i < 4; i++) begin
      wr(8'hd4, 8'h0c | 8'(i % 2));
      pwm[2] = i[1];
      cyc(4);
      chk({7'h0, pout[2]}, {7'h0, i[1] ^ !i[0]});
    end
    clk_en = 1'b0;
    pwm[2] = 1'b0;
    cyc(4);
    chk({7'h0, pout[2]}, 8'h01);
    clk_en = 1'b1;
    $display("t_pwm end");
  endtask
  task automatic final_report();
    $display("checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // clock, sequence and watchdog
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys) rst = 1'b0;
    t_rst();
    t_cmp();
    t_ctc();
    t_cap();
    t_pwm();
    final_report();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    final_report();
  end
endmodule // tb_cca_array
`default_nettype wire
